// ---- verilog/wffc_pkg.sv ----
// Constants for the selective-wake frame filter register block
package wffc_pkg;
  // ********************************************************
  // Register indices; byte address is four times the index
  // ********************************************************
  localparam logic [7:0] IDX_IDENT_12_5  = 8'h25;
  localparam logic [7:0] IDX_IDENT_4_0   = 8'h26;
  localparam logic [7:0] IDX_MASK_28_21  = 8'h27;
  localparam logic [7:0] IDX_MASK_20_13  = 8'h28;
  localparam logic [7:0] IDX_MASK_12_5   = 8'h29;
  localparam logic [7:0] IDX_MASK_4_0    = 8'h2a;
  localparam logic [7:0] IDX_LEN_CODE    = 8'h2b;
  localparam logic [7:0] IDX_PAYLOAD_7   = 8'h2c;
  localparam logic [7:0] IDX_PAYLOAD_6   = 8'h2d;
  localparam logic [7:0] IDX_PAYLOAD_5   = 8'h2e;
  localparam logic [7:0] IDX_WAKE_CTRL   = 8'h3a;
  localparam logic [7:0] IDX_WAKE_STATUS = 8'h3b;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int LO_IDENT_MSB   = 6;
  localparam int LO_IDENT_LSB   = 2;
  localparam int LO_RTR_BIT     = 1;
  localparam int LO_IDE_BIT     = 0;
  localparam int LEN_MSB        = 3;
  localparam int CTRL_CFG_VALID = 0;
  localparam int CTRL_WAKE_EN   = 1;
  localparam int CTRL_SOFT_RST  = 4;
  localparam int STAT_MATCHED   = 0;
  localparam int STAT_REJECTED  = 1;

  // ********************************************************
  // Reset values, lengths and identifier layout
  // ********************************************************
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [4:0]  FIVE_RESET   = 5'h00;
  localparam logic [3:0]  LEN_RESET    = 4'h0;
  localparam logic [3:0]  LEN_MAX      = 4'h8;
  localparam logic [28:0] STD_ID_FIELD = 29'h1ffc_0000;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
endpackage : wffc_pkg

// ---- verilog/wffc_top.sv ----
// APB register block and frame matcher for the selective-wake filter
`timescale 1ns/1ps
// What this block does
// R1: Identifier bits 12..5 live in a full byte register, bit 12 on top.
// R2: Identifier bits 4..0 sit at positions 6..2 of the low register.
// R3: Low register bit 1 gives the expected remote-request bit.
// R4: Low register bit 0 picks standard or extended identifier format.
// R5: Software must never expect a remote frame as a wake frame.
// R6: Mask bit one compares that identifier bit; zero ignores it.
// R7: Mask for identifier bits 28..21 is a full byte register.
// R8: Mask for identifier bits 20..13 is a full byte register.
// R9: Mask for identifier bits 12..5 is a full byte register.
// R10: Mask bits 4..0 at positions 6..2; bits 7, 1, 0 read-only.
// R11: Reserved bits ignore writes and read back zero.
// R12: Length code sits in bits 3..0; any code of eight or more means eight.
// R13: Codes zero to seven mean that many bytes, larger codes mean eight.
// R14: Expected payload bytes seven, six, five are full byte registers.
// R15: Power-on and soft reset clear all these registers to zero.
// R16: Restart keeps the low register top bit at zero.
// R17: Any write of filter settings drops the config-valid flag.
// R18: Standard format compares only identifier bits 28..18.
// R19: Wake only when compared identifier, format, length, data all agree.
module wffc_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_frame_valid,
  input  wire logic [28:0]       rx_ident,
  input  wire logic              rx_ide,
  input  wire logic              rx_rtr,
  input  wire logic [3:0]        rx_len_code,
  input  wire logic [7:0]        rx_payload_byte_seven,
  input  wire logic [7:0]        rx_payload_byte_six,
  input  wire logic [7:0]        rx_payload_byte_five,
  input  wire logic [15:0]       stored_ident_high,
  output logic                   wake_up_frame_match,
  output logic                   selective_wake_en,
  output logic                   config_valid_flag
);
  import wffc_pkg::*;

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [3:0] wffc_eff_len(input logic [3:0] code);
    wffc_eff_len = (code > LEN_MAX) ? LEN_MAX : code; // R13
  endfunction : wffc_eff_len

  // ********************************************************
  // Storage
  // ********************************************************
  logic [7:0]  frame_ident_mid_low_r;
  logic [4:0]  frame_ident_lowest_r;
  logic        rtr_r;
  logic        ide_r;
  logic [7:0]  ident_compare_top_r;
  logic [7:0]  ident_compare_upper_mid_r;
  logic [7:0]  ident_compare_lower_mid_r;
  logic [4:0]  ident_compare_lowest_r;
  logic [3:0]  len_code_r;
  logic [7:0]  payload_byte_seven_r;
  logic [7:0]  payload_byte_six_r;
  logic [7:0]  payload_byte_five_r;
  logic        cfg_valid_r;
  logic        wake_en_r;
  logic        matched_r;
  logic        rejected_r;
  logic        wake_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // ********************************************************
  // Bus decode
  // ********************************************************
  wire [7:0] idx      = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'b00) &&
                        (paddr[ADDR_W-1:10] == '0);
  wire       setup    = psel && !penable;
  wire       wr_acc   = psel && penable && pready_r && pwrite;
  wire       cfg_hit  = (idx >= IDX_IDENT_12_5) && (idx <= IDX_PAYLOAD_5);
  wire       mapped   = aligned && (cfg_hit || idx == IDX_WAKE_CTRL ||
                        idx == IDX_WAKE_STATUS);
  wire       wr_ok    = wr_acc && mapped;
  wire       cfg_wr   = wr_ok && cfg_hit;
  wire       ctrl_wr  = wr_ok && (idx == IDX_WAKE_CTRL);
  wire       soft_clr = ctrl_wr && pwdata[CTRL_SOFT_RST];
  wire       wr_id_hi = wr_ok && (idx == IDX_IDENT_12_5);
  wire       wr_id_lo = wr_ok && (idx == IDX_IDENT_4_0);
  wire       wr_m3    = wr_ok && (idx == IDX_MASK_28_21);
  wire       wr_m2    = wr_ok && (idx == IDX_MASK_20_13);
  wire       wr_m1    = wr_ok && (idx == IDX_MASK_12_5);
  wire       wr_m0    = wr_ok && (idx == IDX_MASK_4_0);
  wire       wr_len   = wr_ok && (idx == IDX_LEN_CODE);
  wire       wr_d7    = wr_ok && (idx == IDX_PAYLOAD_7);
  wire       wr_d6    = wr_ok && (idx == IDX_PAYLOAD_6);
  wire       wr_d5    = wr_ok && (idx == IDX_PAYLOAD_5);

  // Reserved positions are never stored, so they read zero
  wire [7:0] id_lo_view = {1'b0, frame_ident_lowest_r, rtr_r, ide_r};
  wire [7:0] m0_view    = {1'b0, ident_compare_lowest_r, 2'b00};
  wire [7:0] ctrl_view  = {6'h00, wake_en_r, cfg_valid_r};
  wire [7:0] stat_view  = {6'h00, rejected_r, matched_r};
  wire [7:0] rd_byte    =
    (idx == IDX_IDENT_12_5)  ? frame_ident_mid_low_r     :
    (idx == IDX_IDENT_4_0)   ? id_lo_view                : // R16
    (idx == IDX_MASK_28_21)  ? ident_compare_top_r       :
    (idx == IDX_MASK_20_13)  ? ident_compare_upper_mid_r :
    (idx == IDX_MASK_12_5)   ? ident_compare_lower_mid_r :
    (idx == IDX_MASK_4_0)    ? m0_view                   : // R10
    (idx == IDX_LEN_CODE)    ? {4'h0, len_code_r}        : // R11
    (idx == IDX_PAYLOAD_7)   ? payload_byte_seven_r      :
    (idx == IDX_PAYLOAD_6)   ? payload_byte_six_r        :
    (idx == IDX_PAYLOAD_5)   ? payload_byte_five_r       :
    (idx == IDX_WAKE_CTRL)   ? ctrl_view                 :
    (idx == IDX_WAKE_STATUS) ? stat_view                 : BYTE_RESET;
  wire [31:0] rd_word = mapped ? {24'h00_0000, rd_byte} : WORD_ZERO;

  // ********************************************************
  // Frame comparison
  // ********************************************************
  wire [28:0] id_exp   = {stored_ident_high, frame_ident_mid_low_r,
                          frame_ident_lowest_r};
  wire [28:0] id_mask  = {ident_compare_top_r, ident_compare_upper_mid_r,
                          ident_compare_lower_mid_r, ident_compare_lowest_r};
  // Standard frames carry their 11 bits in the top identifier field
  wire [28:0] cmp_mask = ide_r ? id_mask : (id_mask & STD_ID_FIELD); // R18
  wire        id_ok    = ((rx_ident ^ id_exp) & cmp_mask) == '0; // R6
  wire [3:0]  rx_len   = wffc_eff_len(rx_len_code);
  wire        len_ok   = rx_len == wffc_eff_len(len_code_r); // R12
  // Payload byte k only counts when the frame is long enough to carry it
  wire        d7_ok    = (rx_len <= 4'h7) ||
                         (rx_payload_byte_seven == payload_byte_seven_r);
  wire        d6_ok    = (rx_len <= 4'h6) ||
                         (rx_payload_byte_six == payload_byte_six_r);
  wire        d5_ok    = (rx_len <= 4'h5) ||
                         (rx_payload_byte_five == payload_byte_five_r);
  wire        frame_ok = id_ok && (rx_ide == ide_r) && (rx_rtr == rtr_r) &&
                         len_ok && d7_ok && d6_ok && d5_ok; // R19
  wire        armed    = wake_en_r && cfg_valid_r;
  wire        hit      = rx_frame_valid && armed && frame_ok; // R19
  wire        miss     = rx_frame_valid && armed && !frame_ok;

  // ********************************************************
  // Configuration registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!rstn || soft_clr) begin // R15
      frame_ident_mid_low_r     <= BYTE_RESET;
      frame_ident_lowest_r      <= FIVE_RESET;
      rtr_r                     <= 1'b0;
      ide_r                     <= 1'b0;
      ident_compare_top_r       <= BYTE_RESET;
      ident_compare_upper_mid_r <= BYTE_RESET;
      ident_compare_lower_mid_r <= BYTE_RESET;
      ident_compare_lowest_r    <= FIVE_RESET;
      len_code_r                <= LEN_RESET;
      payload_byte_seven_r      <= BYTE_RESET;
      payload_byte_six_r        <= BYTE_RESET;
      payload_byte_five_r       <= BYTE_RESET;
    end else begin
      if (wr_id_hi) frame_ident_mid_low_r <= pwdata[7:0]; // R1
      if (wr_id_lo) begin
        frame_ident_lowest_r <= pwdata[LO_IDENT_MSB:LO_IDENT_LSB]; // R2
        rtr_r                <= pwdata[LO_RTR_BIT]; // R3
        ide_r                <= pwdata[LO_IDE_BIT]; // R4
      end
      if (wr_m3) ident_compare_top_r       <= pwdata[7:0]; // R7
      if (wr_m2) ident_compare_upper_mid_r <= pwdata[7:0]; // R8
      if (wr_m1) ident_compare_lower_mid_r <= pwdata[7:0]; // R9
      if (wr_m0) ident_compare_lowest_r <=
                   pwdata[LO_IDENT_MSB:LO_IDENT_LSB]; // R10
      if (wr_len) len_code_r           <= pwdata[LEN_MSB:0]; // R12
      if (wr_d7)  payload_byte_seven_r <= pwdata[7:0]; // R14
      if (wr_d6)  payload_byte_six_r   <= pwdata[7:0]; // R14
      if (wr_d5)  payload_byte_five_r  <= pwdata[7:0]; // R14
    end
  end

  // ********************************************************
  // Control and status
  // ********************************************************
  // Setting the flag beats the automatic clear in the same cycle
  wire set_valid = ctrl_wr && pwdata[CTRL_CFG_VALID] && !soft_clr;
  wire cfg_valid_nxt = set_valid ? 1'b1 :
                       (cfg_wr || hit || soft_clr) ? 1'b0 : // R17
                       ctrl_wr ? 1'b0 : cfg_valid_r;
  wire wake_en_nxt   = soft_clr ? 1'b0 :
                       ctrl_wr ? pwdata[CTRL_WAKE_EN] : wake_en_r;
  wire stat_wr       = wr_ok && (idx == IDX_WAKE_STATUS);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_valid_r <= 1'b0;
      wake_en_r   <= 1'b0;
      matched_r   <= 1'b0;
      rejected_r  <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      cfg_valid_r <= cfg_valid_nxt;
      wake_en_r   <= wake_en_nxt;
      // Write one to clear; a new event in that cycle wins
      matched_r   <= hit || (matched_r && !(stat_wr &&
                     pwdata[STAT_MATCHED]));
      rejected_r  <= miss || (rejected_r && !(stat_wr &&
                     pwdata[STAT_REJECTED]));
      wake_r      <= hit; // R19
    end
  end

  // ********************************************************
  // APB answer: one wait-free access cycle after setup
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_r  <= WORD_ZERO;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r  <= (setup && !pwrite) ? rd_word : WORD_ZERO; // R11
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign wake_up_frame_match = wake_r;
  assign selective_wake_en   = wake_en_r;
  assign config_valid_flag   = cfg_valid_r;

  // ********************************************************
  // Checks
  // ********************************************************
  sequence write_to(logic [7:0] at);
    wr_ok && idx == at;
  endsequence

  sequence bus_setup;
    psel && !penable;
  endsequence

  apb_answer_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_setup |=> pready_r ##1 !pready_r)
    else $error("APB answer not one cycle after setup");

  ident_mid_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    write_to(IDX_IDENT_12_5) and !soft_clr |=>
      frame_ident_mid_low_r == $past(pwdata[7:0]))
    else $error("Identifier byte 12..5 not stored");

  ident_low_a: assert property (@(posedge clk) disable iff (!rstn) // R2
    write_to(IDX_IDENT_4_0) |=>
      id_lo_view == {1'b0, $past(pwdata[6:0])})
    else $error("Low identifier, remote or format bit not stored");

  mask_low_a: assert property (@(posedge clk) disable iff (!rstn) // R10
    write_to(IDX_MASK_4_0) |=>
      m0_view == {1'b0, $past(pwdata[6:2]), 2'b00})
    else $error("Low mask not stored at positions 6..2");

  resv_read_a: assert property (@(posedge clk) disable iff (!rstn) // R11
    bus_setup and !pwrite and idx == IDX_LEN_CODE |=>
      prdata_r[31:4] == '0)
    else $error("Reserved length bits read non-zero");

  soft_clear_a: assert property (@(posedge clk) disable iff (!rstn) // R15
    soft_clr |=> payload_byte_five_r == BYTE_RESET &&
      ident_compare_top_r == BYTE_RESET && len_code_r == LEN_RESET &&
      !cfg_valid_r)
    else $error("Soft reset left a register set");

  valid_drop_a: assert property (@(posedge clk) disable iff (!rstn) // R17
    cfg_wr |=> !cfg_valid_r)
    else $error("Config-valid survived a settings write");

  mask_block_a: assert property (@(posedge clk) disable iff (!rstn) // R6
    rx_frame_valid && ((rx_ident ^ id_exp) & cmp_mask) != '0 |=>
      !wake_r)
    else $error("Wake despite a compared identifier mismatch");

  long_len_a: assert property (@(posedge clk) disable iff (!rstn) // R13
    hit |-> ((rx_len_code >= LEN_MAX) ? (len_code_r >= LEN_MAX) :
             (len_code_r == rx_len_code)))
    else $error("Long length codes not treated as eight bytes");

  wake_pulse_a: assert property (@(posedge clk) disable iff (!rstn) // R19
    wake_r |-> $past(armed && frame_ok && rx_frame_valid) &&
      (!cfg_valid_r || $past(set_valid)))
    else $error("Wake pulse without an armed full match");

  // ********************************************************
  // Bus error, store and match checks
  // ********************************************************
  apb_error_a: assert property (@(posedge clk) disable iff (!rstn)
    bus_setup and !mapped |=> pready_r && pslverr_r)
    else $error("Unmapped access answered without an error");

  mask_top_a: assert property (@(posedge clk) disable iff (!rstn) // R7
    write_to(IDX_MASK_28_21) |=> ident_compare_top_r == $past(pwdata[7:0]))
    else $error("Mask byte 28..21 not stored");

  mask_upper_a: assert property (@(posedge clk) disable iff (!rstn) // R8
    write_to(IDX_MASK_20_13) |=>
      ident_compare_upper_mid_r == $past(pwdata[7:0]))
    else $error("Mask byte 20..13 not stored");

  mask_lower_a: assert property (@(posedge clk) disable iff (!rstn) // R9
    write_to(IDX_MASK_12_5) |=>
      ident_compare_lower_mid_r == $past(pwdata[7:0]))
    else $error("Mask byte 12..5 not stored");

  len_store_a: assert property (@(posedge clk) disable iff (!rstn) // R12
    write_to(IDX_LEN_CODE) |=> len_code_r == $past(pwdata[LEN_MSB:0]))
    else $error("Length code not stored");

  payload_store_a: assert property (@(posedge clk) disable iff (!rstn) // R14
    write_to(IDX_PAYLOAD_6) |=> payload_byte_six_r == $past(pwdata[7:0]))
    else $error("Payload byte six not stored");

  rtr_block_a: assert property (@(posedge clk) disable iff (!rstn) // R3
    rx_frame_valid && rx_rtr != rtr_r |=> !wake_r)
    else $error("Wake despite a remote-request mismatch");

  ide_block_a: assert property (@(posedge clk) disable iff (!rstn) // R4
    rx_frame_valid && rx_ide != ide_r |=> !wake_r)
    else $error("Wake despite an identifier format mismatch");

  wake_clear_a: assert property (@(posedge clk) disable iff (!rstn) // R17
    hit && !set_valid |=> !cfg_valid_r)
    else $error("Config-valid survived a wake");

  std_ignore_a: assert property (@(posedge clk) disable iff (!rstn) // R18
    rx_frame_valid && armed && !ide_r && !rx_ide && rx_rtr == rtr_r &&
      len_ok && d7_ok && d6_ok && d5_ok &&
      ((rx_ident ^ id_exp) & id_mask & STD_ID_FIELD) == '0 |=> wake_r)
    else $error("Standard frame missed despite matching top bits");
endmodule : wffc_top

// ---- verif/wffc_frame_src.sv ----
// Behavioural CAN receiver that presents received frames to the filter
`timescale 1ns/1ps
module wffc_frame_src (
  input  wire logic        clk,
  output logic             rx_frame_valid,
  output logic [28:0]      rx_ident,
  output logic             rx_ide,
  output logic             rx_rtr,
  output logic [3:0]       rx_len_code,
  output logic [7:0]       rx_payload_byte_seven,
  output logic [7:0]       rx_payload_byte_six,
  output logic [7:0]       rx_payload_byte_five
);
  logic [58:0] fr = 59'h0;

  initial rx_frame_valid = 1'b0;

  assign {rx_ident, rx_ide, rx_rtr, rx_len_code, rx_payload_byte_seven,
          rx_payload_byte_six, rx_payload_byte_five} = fr;

  // ********************************************************
  // One-cycle frame strobe
  // ********************************************************
  task automatic send(input logic [58:0] f);
    @(posedge clk);
    fr <= f;
    rx_frame_valid <= 1'b1;
    @(posedge clk);
    // Inverted afterwards so a late sample cannot pass by luck
    fr <= ~f;
    rx_frame_valid <= 1'b0;
  endtask : send
endmodule : wffc_frame_src

// ---- verif/test_wake_frame_filter_config.sv ----
// Self-checking bench for the selective-wake filter register block
`timescale 1ns/1ps
module test_wake_frame_filter_config;
  import wffc_pkg::*;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [15:0] sih     = 16'h0000;
  logic [31:0] rng     = 32'h0000_005c;
  logic [31:0] prdata, rd, v;
  logic        pready, pslverr, err, wake, wen, cvf, ex;
  logic        rx_v, rx_ide, rx_rtr;
  logic [28:0] rx_id;
  logic [3:0]  rx_len;
  logic [7:0]  b7, b6, b5;
  logic [7:0]  cfg [10];
  logic [58:0] f;
  int          mismatches = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  wffc_top wffc_top_i (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_valid(rx_v), .rx_ident(rx_id), .rx_ide(rx_ide),
    .rx_rtr(rx_rtr), .rx_len_code(rx_len), .rx_payload_byte_seven(b7),
    .rx_payload_byte_six(b6), .rx_payload_byte_five(b5),
    .stored_ident_high(sih), .wake_up_frame_match(wake),
    .selective_wake_en(wen), .config_valid_flag(cvf));

  wffc_frame_src wffc_frame_src_i (.clk(clk), .rx_frame_valid(rx_v),
    .rx_ident(rx_id), .rx_ide(rx_ide), .rx_rtr(rx_rtr),
    .rx_len_code(rx_len), .rx_payload_byte_seven(b7),
    .rx_payload_byte_six(b6), .rx_payload_byte_five(b5));

  // ********************************************************
  // Expectations, compares and bus cycles
  // ********************************************************
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd

  function automatic logic [7:0] wmask(input int k);
    case (k)
      1: return 8'h7f;
      5: return 8'h7c;
      6: return 8'h0f;
      default: return 8'hff;
    endcase
  endfunction : wmask

  function automatic logic [58:0] own_frame();
    return {sih, cfg[0], cfg[1][6:2], cfg[1][0], 1'b0, cfg[6][3:0],
            cfg[7], cfg[8], cfg[9]};
  endfunction : own_frame

  function automatic logic exp_match(input logic [58:0] g);
    logic [28:0] mk;
    logic [3:0]  el, fl;
    logic        ok;
    logic [58:0] o;
    o = own_frame();
    mk = {cfg[2], cfg[3], cfg[4], cfg[5][6:2]};
    if (!cfg[1][0]) mk = mk & STD_ID_FIELD;
    el = (cfg[6][3:0] > 4'h8) ? 4'h8 : cfg[6][3:0];
    fl = (g[27:24] > 4'h8) ? 4'h8 : g[27:24];
    ok = (((g[58:30] ^ o[58:30]) & mk) == 29'h0)
         && g[29] == cfg[1][0] && g[28] == cfg[1][1] && el == fl;
    if (el > 4'h7) ok = ok && g[23:16] == cfg[7];
    if (el > 4'h6) ok = ok && g[15:8] == cfg[8];
    if (el > 4'h5) ok = ok && g[7:0] == cfg[9];
    return ok;
  endfunction : exp_match

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      chk_bit("pready", 1'b1, pready);
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk_word("prdata", {24'h00_0000, e}, rd);
    chk_bit("pslverr", 1'b0, err);
  endtask : rd_chk

  task automatic prog_rand(input logic [7:0] force_val, input logic fv);
    for (int k = 0; k < 10; k++) begin
      v = rnd();
      if (fv) v[7:0] = force_val;
      if (k == 1) v[1] = 1'b0;
      cfg[k] = v[7:0] & wmask(k);
      apb(1'b1, IDX_IDENT_12_5 + 8'(k), v[7:0]);
    end
  endtask : prog_rand

  task automatic read_all();
    for (int k = 0; k < 10; k++) begin
      rd_chk(IDX_IDENT_12_5 + 8'(k), cfg[k]);
    end
  endtask : read_all

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 10; k++) cfg[k] = 8'h00;
    read_all();
    chk_bit("config_valid", 1'b0, cvf);
    $display("test reset_values finished");
    prog_rand(8'hff, 1'b1);
    read_all();
    for (int r = 0; r < 3; r++) begin
      prog_rand(8'h00, 1'b0);
      read_all();
    end
    $display("test readback finished");
    apb(1'b0, 8'h20, 8'h00);
    chk_word("unmapped prdata", 32'h0000_0000, rd);
    chk_bit("unmapped pslverr", 1'b1, err);
    apb(1'b1, IDX_WAKE_CTRL, 8'h03);
    @(negedge clk);
    chk_bit("config_valid", 1'b1, cvf);
    chk_bit("wake_en", 1'b1, wen);
    apb(1'b1, IDX_LEN_CODE, cfg[6]);
    @(negedge clk);
    chk_bit("config_valid", 1'b0, cvf);
    wffc_frame_src_i.send(own_frame());
    @(negedge clk);
    chk_bit("unarmed wake", 1'b0, wake);
    $display("test config_valid finished");
    for (int t = 0; t < 30; t++) begin
      @(posedge clk);
      sih <= 16'(rnd() >> 8);
      prog_rand(8'h00, 1'b0);
      f = own_frame();
      v = rnd();
      case (v[2:0])
        3'h1: f[58:30] = f[58:30] ^ (29'h1 << (v[12:8] % 29));
        3'h2: f[29] = ~f[29];
        3'h3: f[v[20:16] % 24] = ~f[v[20:16] % 24];
        3'h4: f[27:24] = v[27:24];
        3'h5: f[28] = 1'b1;
        default: ;
      endcase
      ex = exp_match(f);
      apb(1'b1, IDX_WAKE_CTRL, 8'h03);
      wffc_frame_src_i.send(f);
      @(negedge clk);
      chk_bit("wake", ex, wake);
      chk_bit("config_valid", !ex, cvf);
      @(negedge clk);
      chk_bit("wake width", 1'b0, wake);
      rd_chk(IDX_WAKE_STATUS, {6'h00, !ex, ex});
      apb(1'b1, IDX_WAKE_STATUS, 8'h03);
    end
    $display("test frame_match finished");
    apb(1'b1, IDX_WAKE_CTRL, 8'h10);
    for (int k = 0; k < 10; k++) cfg[k] = 8'h00;
    read_all();
    chk_bit("wake_en", 1'b0, wen);
    $display("test soft_reset finished");
    summarize();
  end
endmodule : test_wake_frame_filter_config
